// File: srip_pkg.sv
package srip_pkg;
  // clock and line rate
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MAX_BAUD = 4_000_000;
  localparam logic [15:0] MIN_DIV = 16'(CLK_HZ / MAX_BAUD);
  localparam logic [15:0] DIV_RST = 16'h0364;
  // irda pulse is 3/16 of a bit
  localparam int unsigned IR_NUM = 3;
  localparam int unsigned IR_SHIFT = 4;
  // fifo shape
  localparam int unsigned TX_DEPTH = 32;
  localparam int unsigned TX_W = 8;
  localparam int unsigned RX_DEPTH = 32;
  localparam int unsigned RX_W = 16;
  localparam int unsigned FLOW_MARGIN = 4;
  // register offsets
  localparam logic [4:0] A_DATA = 5'h00;
  localparam logic [4:0] A_CTRL = 5'h04;
  localparam logic [4:0] A_DIV = 5'h08;
  localparam logic [4:0] A_THR = 5'h0C;
  localparam logic [4:0] A_STAT = 5'h10;
  localparam logic [4:0] A_IRQ = 5'h14;
  localparam logic [4:0] A_MASK = 5'h18;
  // control fields
  localparam int C_CHAR8 = 0;
  localparam int C_STOP2 = 1;
  localparam int C_PAREN = 2;
  localparam int C_PARODD = 3;
  localparam int C_BRK = 4;
  localparam int C_IRDA = 5;
  localparam int C_DTE = 6;
  localparam int C_AUTO = 7;
  localparam int C_FORCE = 8;
  localparam int C_DMA = 9;
  localparam int C_RTS = 10;
  localparam int C_DTR = 11;
  localparam logic [11:0] CTRL_RST = 12'h001;
  localparam logic [4:0] RXT_RST = 5'h01;
  localparam logic [4:0] TXT_RST = 5'h02;
  // status fields
  localparam int S_CTS = 12;
  localparam int S_CAR = 13;
  localparam int S_RI = 14;
  localparam int S_BUSY = 15;
  // interrupt fields
  localparam int I_RXT = 0;
  localparam int I_TXT = 1;
  localparam int I_MDM = 2;
  localparam int I_RXOV = 3;
  localparam int I_TXOV = 4;
  localparam int I_BRK = 5;
  localparam int I_FERR = 6;
  localparam int I_PERR = 7;
  // receive entry flags
  localparam int E_PERR = 8;
  localparam int E_FERR = 9;
  localparam int E_BRK = 10;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b0_0001,
    TX_START = 5'b0_0010,
    TX_DATA = 5'b0_0100,
    TX_PAR = 5'b0_1000,
    TX_STOP = 5'b1_0000
  } srip_tx_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b0_0001,
    RX_START = 5'b0_0010,
    RX_DATA = 5'b0_0100,
    RX_PAR = 5'b0_1000,
    RX_STOP = 5'b1_0000
  } srip_rx_t;
endpackage

// File: srip_uart.sv
`timescale 1ns/1ps
// Function
// (R1) characters of 7 or 8 data bits, chosen by control, both ends alike
// (R2) one or two stop bits after each sent character
// (R3) odd or even parity sent; parity and framing errors flagged on receive
// (R4) break driven on request; received break detected and reported
// (R5) transmit fifo of 32 byte entries
// (R6) receive fifo of 32 half-word entries
// (R7) maskable interrupt when a fifo level reaches its threshold
// (R8) maskable interrupt on any modem input change
// (R9) dce or dte mode sets modem line meaning
// (R10) cts and carrier readable; ring readable only in dte mode
// (R11) software sets only rts and dtr outputs
// (R12) automatic or manual cts/rts flow control
// (R13) software can force flow output off; release returns automatic control
// (R14) irda 1.0 pulse signalling as an alternative line mode
// (R15) baud generator reaches 4 Mbps
// (R16) remote side uses the configured baud rate; no autobaud
// (R17) dma requests for both fifos when dma enabled
// (R18) receive entry holds character low, error flags high
// (R19) full fifo keeps entries and sets overrun flag
module srip_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_push,
  input wire logic [W-1:0] i_wdata,
  input wire logic i_pop,
  output logic [W-1:0] o_rdata,
  output logic o_full,
  output logic o_empty,
  output logic [$clog2(D):0] o_level
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] lvl_q;
  logic do_push;
  logic do_pop;
  // full fifo refuses pushes, keeping entries
  assign do_push = i_push && !o_full; // R19
  assign do_pop = i_pop && !o_empty;
  assign o_full = lvl_q == (AW+1)'(D);
  assign o_empty = lvl_q == '0;
  assign o_level = lvl_q;
  assign o_rdata = mem[rp_q];
  // storage
  always_ff @(posedge i_mclk)
  begin
    if (do_push)
    begin
      mem[wp_q] <= i_wdata;
    end
  end
  // pointers and level
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wp_q <= '0;
      rp_q <= '0;
      lvl_q <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_pop)
      begin
        rp_q <= rp_q + 1'b1;
      end
      lvl_q <= lvl_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

module srip_uart (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_irq,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_ir_rx,
  output logic o_ir_tx,
  input wire logic i_ctl_a_n,
  input wire logic i_ctl_b_n,
  input wire logic i_ctl_c_n,
  output logic o_ctl_a_n,
  output logic o_ctl_b_n,
  output logic o_tx_dma_req,
  output logic o_rx_dma_req
);
  logic [11:0] ctrl_q;
  logic [15:0] div_q;
  logic [4:0] rxt_q;
  logic [4:0] txt_q;
  logic [7:0] stat_q;
  logic [7:0] mask_q;
  logic [7:0] ev;
  logic [15:0] rdata_q;
  logic [2:0] mdm_q;
  logic tx_full, tx_empty, rx_full, rx_empty;
  logic [5:0] tx_lvl, rx_lvl;
  logic [7:0] tx_head;
  logic [15:0] rx_head;
  logic wr_data, rd_data, tx_pop, rx_push, tx_go, flow_ok;
  logic [15:0] rx_entry;
  srip_pkg::srip_tx_t tx_st_q;
  srip_pkg::srip_rx_t rx_st_q;
  logic [15:0] tx_cnt_q, rx_cnt_q, ir_cnt_q, ir_w;
  logic [2:0] tx_bit_q, rx_bit_q, last_bit;
  logic [7:0] tx_sh_q, rx_sh_q;
  logic tx_par_q, tx_line_q, rx_par_q, rx_any_q, rx_perr_q, rx_prev_q, rx_in;
  logic txd_q, ir_q, cta_q, ctb_q;

  // bus decode
  assign wr_data = i_wr && i_addr == srip_pkg::A_DATA;
  assign rd_data = i_rd && i_addr == srip_pkg::A_DATA;
  assign last_bit = ctrl_q[srip_pkg::C_CHAR8] ? 3'h7 : 3'h6; // R1

  // control registers
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl_q <= srip_pkg::CTRL_RST;
      div_q <= srip_pkg::DIV_RST;
      rxt_q <= srip_pkg::RXT_RST;
      txt_q <= srip_pkg::TXT_RST;
      mask_q <= '0;
    end
    else if (i_wr)
    begin
      case (i_addr)
        srip_pkg::A_CTRL: ctrl_q <= i_wdata[11:0]; // R9 R11
        // divisor held at or above the 4 Mbps floor
        srip_pkg::A_DIV: div_q <= (i_wdata < srip_pkg::MIN_DIV) ? srip_pkg::MIN_DIV : i_wdata; // R15
        srip_pkg::A_THR:
        begin
          rxt_q <= i_wdata[4:0];
          txt_q <= i_wdata[12:8];
        end
        srip_pkg::A_MASK: mask_q <= i_wdata[7:0];
        default: ;
      endcase
    end
  end

  // read data, one cycle after the strobe only
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rdata_q <= '0;
    end
    else if (!i_rd)
    begin
      rdata_q <= '0;
    end
    else
    begin
      case (i_addr)
        srip_pkg::A_DATA: rdata_q <= rx_empty ? 16'h0000 : rx_head;
        srip_pkg::A_CTRL: rdata_q <= {4'h0, ctrl_q};
        srip_pkg::A_DIV: rdata_q <= div_q;
        srip_pkg::A_THR: rdata_q <= {3'h0, txt_q, 3'h0, rxt_q};
        srip_pkg::A_STAT: rdata_q <= {tx_st_q != srip_pkg::TX_IDLE,
          ctrl_q[srip_pkg::C_DTE] & ~i_ctl_c_n, ~i_ctl_b_n, ~i_ctl_a_n, tx_lvl, rx_lvl}; // R10
        srip_pkg::A_IRQ: rdata_q <= {8'h00, stat_q};
        srip_pkg::A_MASK: rdata_q <= {8'h00, mask_q};
        default: rdata_q <= '0;
      endcase
    end
  end
  assign o_rdata = rdata_q;

  // fifos
  srip_fifo #(.W(srip_pkg::TX_W), .D(srip_pkg::TX_DEPTH)) u_txf ( // R5
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_push(wr_data), .i_wdata(i_wdata[7:0]),
    .i_pop(tx_pop), .o_rdata(tx_head), .o_full(tx_full), .o_empty(tx_empty), .o_level(tx_lvl));
  srip_fifo #(.W(srip_pkg::RX_W), .D(srip_pkg::RX_DEPTH)) u_rxf ( // R6
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_push(rx_push), .i_wdata(rx_entry),
    .i_pop(rd_data), .o_rdata(rx_head), .o_full(rx_full), .o_empty(rx_empty), .o_level(rx_lvl));

  // events and sticky status, set beats clear
  assign ev[srip_pkg::I_RXT] = rx_lvl >= {1'b0, rxt_q}; // R7
  assign ev[srip_pkg::I_TXT] = tx_lvl <= {1'b0, txt_q}; // R7
  assign ev[srip_pkg::I_MDM] = mdm_q != {i_ctl_a_n, i_ctl_b_n, i_ctl_c_n}; // R8
  assign ev[srip_pkg::I_RXOV] = rx_push && rx_full; // R19
  assign ev[srip_pkg::I_TXOV] = wr_data && tx_full; // R19
  assign ev[srip_pkg::I_BRK] = rx_push && rx_entry[srip_pkg::E_BRK]; // R4
  assign ev[srip_pkg::I_FERR] = rx_push && rx_entry[srip_pkg::E_FERR]; // R3
  assign ev[srip_pkg::I_PERR] = rx_push && rx_entry[srip_pkg::E_PERR]; // R3
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      stat_q <= '0;
      mdm_q <= 3'h7;
    end
    else
    begin
      mdm_q <= {i_ctl_a_n, i_ctl_b_n, i_ctl_c_n};
      stat_q <= ev | (stat_q & ~((i_wr && i_addr == srip_pkg::A_IRQ) ? i_wdata[7:0] : 8'h00));
    end
  end
  assign o_irq = |(stat_q & mask_q); // R7 R8

  // dma requests from fifo levels
  assign o_tx_dma_req = ctrl_q[srip_pkg::C_DMA] && ev[srip_pkg::I_TXT]; // R17
  assign o_rx_dma_req = ctrl_q[srip_pkg::C_DMA] && ev[srip_pkg::I_RXT] && !rx_empty; // R17

  // flow gating of the transmitter
  assign flow_ok = !ctrl_q[srip_pkg::C_AUTO] || !i_ctl_a_n; // R12
  assign tx_go = tx_st_q == srip_pkg::TX_IDLE && !tx_empty && flow_ok && !ctrl_q[srip_pkg::C_BRK];
  assign tx_pop = tx_go;

  // transmitter, bit enable from its divider
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      tx_st_q <= srip_pkg::TX_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= '0;
      tx_par_q <= 1'b0;
      tx_line_q <= 1'b1;
    end
    else if (tx_st_q == srip_pkg::TX_IDLE)
    begin
      tx_line_q <= 1'b1;
      if (tx_go)
      begin
        tx_st_q <= srip_pkg::TX_START;
        tx_line_q <= 1'b0;
        tx_cnt_q <= div_q - 16'h0001;
        tx_sh_q <= tx_head;
        tx_bit_q <= '0;
        tx_par_q <= ^(tx_head & {ctrl_q[srip_pkg::C_CHAR8], 7'h7F}) ^ ctrl_q[srip_pkg::C_PARODD]; // R3
      end
    end
    else if (tx_cnt_q != '0)
    begin
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    end
    else
    begin
      tx_cnt_q <= div_q - 16'h0001;
      case (tx_st_q)
        srip_pkg::TX_START:
        begin
          tx_st_q <= srip_pkg::TX_DATA;
          tx_line_q <= tx_sh_q[0];
          tx_sh_q <= {1'b0, tx_sh_q[7:1]};
        end
        srip_pkg::TX_DATA:
          if (tx_bit_q == last_bit) // R1
          begin
            tx_bit_q <= '0;
            tx_st_q <= ctrl_q[srip_pkg::C_PAREN] ? srip_pkg::TX_PAR : srip_pkg::TX_STOP;
            tx_line_q <= ctrl_q[srip_pkg::C_PAREN] ? tx_par_q : 1'b1; // R3
          end
          else
          begin
            tx_bit_q <= tx_bit_q + 3'h1;
            tx_line_q <= tx_sh_q[0];
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
          end
        srip_pkg::TX_PAR:
        begin
          tx_st_q <= srip_pkg::TX_STOP;
          tx_line_q <= 1'b1;
        end
        srip_pkg::TX_STOP:
          if (ctrl_q[srip_pkg::C_STOP2] && tx_bit_q == '0) // R2
          begin
            tx_bit_q <= 3'h1;
          end
          else
          begin
            tx_st_q <= srip_pkg::TX_IDLE;
          end
        default: tx_st_q <= srip_pkg::TX_IDLE;
      endcase
    end
  end

  // line drivers: break and irda pulses
  assign ir_w = ((div_q * 16'(srip_pkg::IR_NUM)) >> srip_pkg::IR_SHIFT) | 16'h0001;
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      txd_q <= 1'b1;
      ir_q <= 1'b0;
    end
    else
    begin
      txd_q <= tx_line_q && !ctrl_q[srip_pkg::C_BRK]; // R4
      ir_q <= ctrl_q[srip_pkg::C_IRDA] && (ctrl_q[srip_pkg::C_BRK] || (!tx_line_q &&
        tx_cnt_q >= div_q - ir_w)); // R14
    end
  end
  assign o_txd = txd_q;
  assign o_ir_tx = ir_q;

  // irda receive pulse stretched to a low bit
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ir_cnt_q <= '0;
    end
    else if (i_ir_rx)
    begin
      ir_cnt_q <= div_q;
    end
    else if (ir_cnt_q != '0)
    begin
      ir_cnt_q <= ir_cnt_q - 16'h0001;
    end
  end
  assign rx_in = ctrl_q[srip_pkg::C_IRDA] ? (ir_cnt_q == '0) : i_rxd; // R14

  // receive entry: character low, flags high
  assign rx_entry = {5'h00, ~rx_in & ~rx_any_q, ~rx_in, rx_perr_q,
    ctrl_q[srip_pkg::C_CHAR8] ? rx_sh_q : {1'b0, rx_sh_q[7:1]}}; // R18
  assign rx_push = rx_st_q == srip_pkg::RX_STOP && rx_cnt_q == '0;

  // receiver, mid-bit sampling
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rx_st_q <= srip_pkg::RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_par_q <= 1'b0;
      rx_any_q <= 1'b0;
      rx_perr_q <= 1'b0;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      rx_prev_q <= rx_in;
      if (rx_st_q == srip_pkg::RX_IDLE)
      begin
        if (rx_prev_q && !rx_in)
        begin
          rx_st_q <= srip_pkg::RX_START;
          rx_cnt_q <= div_q >> 1;
          rx_bit_q <= '0;
          rx_par_q <= 1'b0;
          rx_any_q <= 1'b0;
          rx_perr_q <= 1'b0;
        end
      end
      else if (rx_cnt_q != '0)
      begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end
      else
      begin
        rx_cnt_q <= div_q - 16'h0001;
        case (rx_st_q)
          srip_pkg::RX_START: rx_st_q <= rx_in ? srip_pkg::RX_IDLE : srip_pkg::RX_DATA;
          srip_pkg::RX_DATA:
          begin
            rx_sh_q <= {rx_in, rx_sh_q[7:1]};
            rx_par_q <= rx_par_q ^ rx_in;
            rx_any_q <= rx_any_q | rx_in;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == last_bit) // R1
            begin
              rx_st_q <= ctrl_q[srip_pkg::C_PAREN] ? srip_pkg::RX_PAR : srip_pkg::RX_STOP;
            end
          end
          srip_pkg::RX_PAR:
          begin
            rx_perr_q <= rx_par_q ^ rx_in ^ ctrl_q[srip_pkg::C_PARODD]; // R3
            rx_any_q <= rx_any_q | rx_in;
            rx_st_q <= srip_pkg::RX_STOP;
          end
          srip_pkg::RX_STOP: rx_st_q <= srip_pkg::RX_IDLE; // R3 R4
          default: rx_st_q <= srip_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // modem outputs: flow line and dtr
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cta_q <= 1'b1;
      ctb_q <= 1'b1;
    end
    else
    begin
      if (ctrl_q[srip_pkg::C_FORCE]) // R13
      begin
        cta_q <= 1'b1;
      end
      else if (ctrl_q[srip_pkg::C_AUTO]) // R12
      begin
        cta_q <= !(rx_lvl < 6'(srip_pkg::RX_DEPTH - srip_pkg::FLOW_MARGIN));
      end
      else
      begin
        cta_q <= !ctrl_q[srip_pkg::C_RTS]; // R11
      end
      ctb_q <= !ctrl_q[srip_pkg::C_DTR]; // R11
    end
  end
  assign o_ctl_a_n = cta_q;
  assign o_ctl_b_n = ctb_q;

  // checks
  sequence s_tx_launch;
    tx_st_q == srip_pkg::TX_IDLE ##1 tx_st_q == srip_pkg::TX_START;
  endsequence
  property p_brk;
    @(posedge i_mclk) disable iff (!i_resetn) ctrl_q[srip_pkg::C_BRK] |=> !o_txd;
  endproperty
  a_brk: assert property (p_brk) else $error("break not driven"); // R4
  property p_start;
    @(posedge i_mclk) disable iff (!i_resetn) s_tx_launch ##0 !ctrl_q[srip_pkg::C_BRK] |=> !o_txd;
  endproperty
  a_start: assert property (p_start) else $error("start bit not low"); // R1
  property p_stop;
    @(posedge i_mclk) disable iff (!i_resetn)
      tx_st_q == srip_pkg::TX_STOP && !ctrl_q[srip_pkg::C_BRK] |=> o_txd;
  endproperty
  a_stop: assert property (p_stop) else $error("stop bit not high"); // R2
  property p_txov;
    @(posedge i_mclk) disable iff (!i_resetn) wr_data && tx_full |=>
      stat_q[srip_pkg::I_TXOV] && tx_lvl == $past(tx_lvl) - 6'($past(tx_pop));
  endproperty
  a_txov: assert property (p_txov) else $error("tx overrun missed"); // R19
  property p_rxt;
    @(posedge i_mclk) disable iff (!i_resetn) ev[srip_pkg::I_RXT] && mask_q[srip_pkg::I_RXT] |=> o_irq;
  endproperty
  a_rxt: assert property (p_rxt) else $error("threshold irq missing"); // R7
  property p_mdm;
    @(posedge i_mclk) disable iff (!i_resetn) $changed(i_ctl_b_n) |=> stat_q[srip_pkg::I_MDM];
  endproperty
  a_mdm: assert property (p_mdm) else $error("modem change missed"); // R8
  property p_ri;
    @(posedge i_mclk) disable iff (!i_resetn)
      i_rd && i_addr == srip_pkg::A_STAT && !ctrl_q[srip_pkg::C_DTE] |=> !o_rdata[srip_pkg::S_RI];
  endproperty
  a_ri: assert property (p_ri) else $error("ring visible in dce"); // R10
  property p_gate;
    @(posedge i_mclk) disable iff (!i_resetn)
      tx_st_q == srip_pkg::TX_IDLE && ctrl_q[srip_pkg::C_AUTO] && i_ctl_a_n |=> tx_st_q == srip_pkg::TX_IDLE;
  endproperty
  a_gate: assert property (p_gate) else $error("sent while flow off"); // R12
  property p_force;
    @(posedge i_mclk) disable iff (!i_resetn) ctrl_q[srip_pkg::C_FORCE] |=> o_ctl_a_n;
  endproperty
  a_force: assert property (p_force) else $error("flow output not forced off"); // R13
endmodule

// File: srip_peer.sv
`timescale 1ns/1ps
// remote terminal: checks frames sent to it, sends frames, drives modem lines
module srip_peer #(
  parameter int DIV = 25
) (
  input wire logic i_mclk,
  input wire logic i_line,
  input wire logic i_char8,
  input wire logic i_paren,
  input wire logic i_parodd,
  output logic o_line,
  output logic o_got,
  output logic [7:0] o_data,
  output logic o_par_ok,
  output logic o_stop_ok,
  output int o_gap,
  output logic o_ctl_a_n,
  output logic o_ctl_b_n,
  output logic o_ctl_c_n
);
  int cyc = 0;
  int last = 0;
  int k;
  logic p;
  // free cycle count for frame spacing
  always @(posedge i_mclk) cyc <= cyc + 1;
  // one bit held for a full bit time
  task automatic bitout(input logic b);
    o_line <= b;
    repeat (DIV) @(posedge i_mclk);
  endtask
  // one frame at the agreed rate, parity or stop spoiled on demand
  task automatic send(input logic [7:0] d, input bit bad_par, input bit bad_stop);
    logic q;
    int i;
    q = i_parodd ^ bad_par;
    @(posedge i_mclk);
    bitout(1'b0);
    for (i = 0; i < (i_char8 ? 8 : 7); i++)
    begin
      bitout(d[i]);
      q = q ^ d[i];
    end
    if (i_paren)
      bitout(q);
    bitout(!bad_stop);
    o_line <= 1'b1;
    repeat (DIV) @(posedge i_mclk);
  endtask
  // modem lines towards the port, low active
  task automatic set_ctl(input logic a, input logic b, input logic c);
    o_ctl_a_n <= a;
    o_ctl_b_n <= b;
    o_ctl_c_n <= c;
  endtask
  // receiver samples mid-bit on the falling edge, clear of the sender's edge
  initial
  begin
    o_line = 1'b1;
    o_got = 1'b0;
    o_ctl_a_n = 1'b0;
    o_ctl_b_n = 1'b1;
    o_ctl_c_n = 1'b1;
    forever
    begin
      @(negedge i_mclk);
      if (i_line === 1'b0)
      begin
        o_gap = cyc - last;
        last = cyc;
        p = i_parodd;
        o_data = 8'h00;
        repeat (DIV / 2) @(negedge i_mclk);
        for (k = 0; k < (i_char8 ? 8 : 7); k++)
        begin
          repeat (DIV) @(negedge i_mclk);
          o_data[k] = i_line;
          p = p ^ i_line;
        end
        if (i_paren)
        begin
          repeat (DIV) @(negedge i_mclk);
          p = p ^ i_line;
        end
        repeat (DIV) @(negedge i_mclk);
        o_stop_ok = i_line;
        o_par_ok = !i_paren || !p;
        o_got = 1'b1;
        @(negedge i_mclk);
        o_got = 1'b0;
        // a held-low line (break) is one frame, not many
        while (i_line !== 1'b1) @(negedge i_mclk);
      end
    end
  end
endmodule

// File: test_srip_uart.sv
`timescale 1ns/1ps
// self-checking bench for the serial port
module test_srip_uart;
  typedef struct {string n; logic [15:0] v; logic [15:0] m;} srip_rd_t;
  typedef struct {logic [7:0] d; logic s; int g;} srip_ch_t;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic o_irq, o_txd, o_ir_tx, o_ctl_a_n, o_ctl_b_n, o_tx_dma_req, o_rx_dma_req;
  logic i_rxd, i_ctl_a_n, i_ctl_b_n, i_ctl_c_n;
  logic [11:0] ctrl_v = 12'h201;
  logic [15:0] rnd = 16'hAEB9;
  logic [7:0] dm;
  logic rd_pend = 1'b0;
  logic ir_rx = 1'b0;
  int fail_count = 0;
  int cmp_count = 0;
  int f;
  srip_rd_t rq[$];
  srip_ch_t tq[$];
  srip_rd_t r;
  srip_ch_t e;
  logic [11:0] cfg [4] = '{12'h200, 12'h203, 12'h205, 12'h20E};

  srip_uart dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_rxd(i_rxd), .o_txd(o_txd), .i_ir_rx(ir_rx),
    .o_ir_tx(o_ir_tx), .i_ctl_a_n(i_ctl_a_n), .i_ctl_b_n(i_ctl_b_n), .i_ctl_c_n(i_ctl_c_n),
    .o_ctl_a_n(o_ctl_a_n), .o_ctl_b_n(o_ctl_b_n), .o_tx_dma_req(o_tx_dma_req), .o_rx_dma_req(o_rx_dma_req));
  srip_peer #(.DIV(25)) peer (.i_mclk(i_mclk), .i_line(o_txd), .i_char8(ctrl_v[0]), .i_paren(ctrl_v[2]),
    .i_parodd(ctrl_v[3]), .o_line(i_rxd), .o_got(), .o_data(), .o_par_ok(), .o_stop_ok(), .o_gap(),
    .o_ctl_a_n(i_ctl_a_n), .o_ctl_b_n(i_ctl_b_n), .o_ctl_c_n(i_ctl_c_n));

  // 100 MHz clock
  initial
  begin
    forever #5 i_mclk = ~i_mclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (rq.size() != 0 || tq.size() != 0)
    begin
      fail_count++;
      $display("unexpected pending notes expected 0 seen %0d", rq.size() + tq.size());
    end
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic rst();
    i_resetn <= 1'b0;
    repeat (12) @(posedge i_mclk);
    i_resetn <= 1'b1;
    @(posedge i_mclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // read strobe with its expectation noted for the answer watcher
  task automatic rd(input logic [4:0] a, input logic [15:0] v, input logic [15:0] m, input string n);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    rq.push_back('{n, v, m});
    @(posedge i_mclk);
    i_rd <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask

  task automatic drain();
    for (f = 0; f < 3000 && tq.size() != 0; f++) @(posedge i_mclk);
    settle(60);
  endtask

  // one received character: interrupt, dma request, entry, then clear
  task automatic rx1(input logic [7:0] dd, input bit bp, input bit bs, input logic [15:0] fl);
    dm = dd & (ctrl_v[0] ? 8'hFF : 8'h7F);
    peer.send(dd, bp, bs);
    settle(1);
    chk("rx irq", o_irq, 1'b1);
    chk("rx dma", o_rx_dma_req, 1'b1);
    rd(srip_pkg::A_DATA, fl | {8'h00, dm}, 16'hFFFF, "rx entry");
    wr(srip_pkg::A_IRQ, 16'h00FF);
    settle(2);
    chk("rx irq clear", o_irq, 1'b0);
  endtask

  // read answers stand in the cycle after the strobe
  always @(posedge i_mclk) rd_pend <= i_rd;
  always @(negedge i_mclk)
  begin
    if (rd_pend)
    begin
      r = rq.pop_front();
      chk(r.n, o_rdata & r.m, r.v & r.m);
    end
  end

  // frames seen by the far end against the noted characters
  always @(posedge peer.o_got)
  begin
    if (tq.size() == 0)
      chk("tx frame count", 1'b1, 1'b0);
    else
    begin
      e = tq.pop_front();
      chk("tx data", peer.o_data, e.d);
      chk("tx parity", peer.o_par_ok, 1'b1);
      chk("tx stop", peer.o_stop_ok, e.s);
      if (e.g != 0)
        chk("tx spacing", peer.o_gap >= e.g && peer.o_gap <= e.g + 2, 1'b1);
    end
  end

  // watchdog cuts a hang short
  initial
  begin
    repeat (60000) @(posedge i_mclk);
    fail_count++;
    $display("unexpected timeout expected finish seen hang");
    end_of_test();
  end

  initial
  begin
    rst();
    rd(srip_pkg::A_CTRL, 16'h0001, 16'hFFFF, "ctrl reset");
    rd(srip_pkg::A_DIV, 16'h0364, 16'hFFFF, "div reset");
    rd(srip_pkg::A_THR, 16'h0201, 16'hFFFF, "thr reset");
    rd(5'h1C, 16'h0000, 16'hFFFF, "unmapped");
    wr(srip_pkg::A_DIV, 16'h0005);
    rd(srip_pkg::A_DIV, 16'h0019, 16'hFFFF, "div clamp");
    wr(srip_pkg::A_DIV, 16'h0019);
    settle(1);
    chk("txd idle", o_txd, 1'b1);
    $display("test registers done");
    // modem inputs, mode, outputs and flow override
    wr(srip_pkg::A_MASK, 16'h0004);
    wr(srip_pkg::A_IRQ, 16'h0004);
    settle(2);
    chk("modem irq idle", o_irq, 1'b0);
    @(posedge i_mclk);
    peer.set_ctl(1'b0, 1'b0, 1'b0);
    settle(3);
    chk("modem irq", o_irq, 1'b1);
    wr(srip_pkg::A_IRQ, 16'h0004);
    settle(2);
    chk("modem irq clear", o_irq, 1'b0);
    rd(srip_pkg::A_STAT, 16'h3000, 16'h7000, "lines dce");
    wr(srip_pkg::A_CTRL, 16'h0C41);
    rd(srip_pkg::A_STAT, 16'h7000, 16'h7000, "lines dte");
    settle(2);
    chk("rts out", o_ctl_a_n, 1'b0);
    chk("dtr out", o_ctl_b_n, 1'b0);
    wr(srip_pkg::A_CTRL, 16'h0D41);
    settle(2);
    chk("flow forced off", o_ctl_a_n, 1'b1);
    wr(srip_pkg::A_CTRL, 16'h0081);
    settle(2);
    chk("flow back to auto", o_ctl_a_n, 1'b0);
    wr(srip_pkg::A_MASK, 16'h0001);
    $display("test modem done");
    // two characters back to back per frame format
    foreach (cfg[c])
    begin
      ctrl_v = cfg[c];
      wr(srip_pkg::A_CTRL, {4'h0, ctrl_v});
      settle(1);
      chk("tx dma", o_tx_dma_req, 1'b1);
      f = 25 * (2 + (ctrl_v[0] ? 8 : 7) + ctrl_v[2] + ctrl_v[1]);
      for (int k = 0; k < 2; k++)
      begin
        rnd = lfsr(rnd);
        tq.push_back('{rnd[7:0] & (ctrl_v[0] ? 8'hFF : 8'h7F), 1'b1, k ? f : 0});
        wr(srip_pkg::A_DATA, {8'h00, rnd[7:0]});
      end
      drain();
    end
    ctrl_v = 12'h201;
    wr(srip_pkg::A_CTRL, 16'h0201);
    tq.push_back('{8'h00, 1'b0, 0});
    wr(srip_pkg::A_CTRL, 16'h0211);
    settle(300);
    chk("tx break", o_txd, 1'b0);
    wr(srip_pkg::A_CTRL, 16'h0201);
    drain();
    $display("test transmit done");
    // good, bad parity, bad stop and break characters
    foreach (cfg[c])
    begin
      ctrl_v = cfg[c];
      wr(srip_pkg::A_CTRL, {4'h0, ctrl_v});
      rnd = lfsr(rnd);
      rx1(rnd[7:0], 1'b0, 1'b0, 16'h0000);
      if (ctrl_v[2])
        rx1(rnd[7:0], 1'b1, 1'b0, 16'h0100);
      rx1(rnd[7:0] | 8'h01, 1'b0, 1'b1, 16'h0200);
    end
    ctrl_v = 12'h201;
    wr(srip_pkg::A_CTRL, 16'h0201);
    rx1(8'h00, 1'b0, 1'b1, 16'h0600);
    // irda: a sent zero bit pulses, one received pulse is a start bit
    wr(srip_pkg::A_CTRL, 16'h0221);
    tq.push_back('{8'hFF, 1'b1, 0});
    wr(srip_pkg::A_DATA, 16'h00FF);
    settle(2);
    chk("ir tx pulse", o_ir_tx, 1'b1);
    settle(5);
    chk("ir tx pulse end", o_ir_tx, 1'b0);
    @(posedge i_mclk);
    ir_rx <= 1'b1;
    @(posedge i_mclk);
    ir_rx <= 1'b0;
    settle(300);
    rd(srip_pkg::A_DATA, 16'h00FF, 16'hFFFF, "irda rx");
    $display("test receive done");
    // far end holds flow off: both fifos fill, overrun, nothing sent
    peer.set_ctl(1'b1, 1'b0, 1'b0);
    wr(srip_pkg::A_CTRL, 16'h0081);
    for (int k = 0; k < 33; k++)
    begin
      peer.send(8'h55, 1'b0, 1'b0);
      chk("flow out", o_ctl_a_n, k + 1 >= srip_pkg::RX_DEPTH - srip_pkg::FLOW_MARGIN);
    end
    for (int k = 0; k < 33; k++)
    begin
      rnd = lfsr(rnd);
      wr(srip_pkg::A_DATA, {8'h00, rnd[7:0]});
    end
    rd(srip_pkg::A_STAT, 16'h0820, 16'h0FFF, "fifo levels full");
    rd(srip_pkg::A_IRQ, 16'h0018, 16'h0018, "overruns");
    settle(1);
    chk("tx held", o_txd, 1'b1);
    wr(srip_pkg::A_CTRL, 16'h0281);
    settle(1);
    chk("tx dma full", o_tx_dma_req, 1'b0);
    rst();
    rd(srip_pkg::A_STAT, 16'h0000, 16'h0FFF, "levels after reset");
    settle(400);
    $display("test overrun done");
    end_of_test();
  end
endmodule
